/* File: core/cfgl_defs.svh */
// offsets, field positions, reset values and counts of the config loader
`ifndef CFGL_DEFS_SVH
`define CFGL_DEFS_SVH

`define CFGL_NUM_CFG 16
`define CFGL_IDX_W 4
`define CFGL_IDX_LAST 4'hF
`define CFGL_SYNC_W 4

`define CFGL_OFF_B2_FAULT 8'h4F
`define CFGL_OFF_B2_LIMIT 8'h50
`define CFGL_OFF_B2_SLOT 8'h51
`define CFGL_OFF_B2_MODE 8'h52
`define CFGL_OFF_B2_ACTV 8'h53
`define CFGL_OFF_B2_STBY 8'h54
`define CFGL_OFF_AUX_LIMIT 8'h68
`define CFGL_OFF_AUX_SLOT 8'h69
`define CFGL_OFF_AUX_MODE 8'h6A
`define CFGL_OFF_AUX_ACTV 8'h6B
`define CFGL_OFF_LIN_FAULT 8'h6E
`define CFGL_OFF_LIN_EN 8'h6F
`define CFGL_OFF_LIN_SLOT 8'h70
`define CFGL_OFF_LIN_ACTV 8'h71
`define CFGL_OFF_LIN_STBY 8'h72
`define CFGL_OFF_BACKUP 8'h75
`define CFGL_OFF_PAGE 8'h77
`define CFGL_OFF_FLAGS 8'h7A

`define CFGL_PAGE_MSB 2
`define CFGL_PAGE_MIRROR 3'h1
`define CFGL_PAGE_RESET 3'h0
`define CFGL_FLAG_TRIM 0
`define CFGL_FLAG_FUSE 1
`define CFGL_FLAG_STEST 2
`define CFGL_CFG_RESET 8'h00
`define CFGL_HW_DEFAULT 8'h00

`define CFGL_PIN_SRC 0
`define CFGL_PIN_TRIAL 1
`define CFGL_PIN_SUPPLY 2
`define CFGL_PIN_POWER_UP_REQUEST 3

`endif

/* File: core/cfgl_pkg.sv */
// types shared by the config loader files
package cfgl_pkg;
	typedef logic [15:0][7:0] cfgl_bank_t;

	typedef enum logic [2:0] {
		ST_UNPOWERED,
		ST_FUSE_COPY,
		ST_FUNC_LOAD,
		ST_QUIESCENT,
		ST_ACTIVE
	} cfgl_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] data;
	} cfgl_regreq_t;

	typedef struct packed {
		logic selftest;
		logic fuse;
		logic trim;
	} cfgl_flags_t;
endpackage

/* File: core/cfgl_sync.sv */
// two-flop synchronisers for the strap, supply and power-up request pins
`timescale 1ns/1ps
module cfgl_sync (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] asyncIn,
	output logic [3:0] syncOut
);
	logic [3:0] stage1_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stage1_reg <= 4'h0;
			syncOut <= 4'h0;
		end else begin
			stage1_reg <= asyncIn;
			syncOut <= stage1_reg;
		end
	end
endmodule

/* File: core/cfgl_mirror_bank.sv */
// fuse mirror bank: fuse copy sequencer plus host-writable mirror storage
`timescale 1ns/1ps
`include "cfgl_defs.svh"
module cfgl_mirror_bank (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clearAll,
	input wire logic copyStart,
	output logic fuseRd,
	output logic [3:0] fuseAddr,
	input wire logic [7:0] fuseRdData,
	input wire logic fuseRdErr,
	input wire logic hostWr,
	input wire logic [3:0] hostIdx,
	input wire logic [7:0] hostData,
	output cfgl_pkg::cfgl_bank_t mirror,
	output logic copyBusy,
	output logic copyDone,
	output logic copyErr
);
	logic pend_reg;
	logic [3:0] pendAddr_reg;
	logic errAcc_reg;
	logic [7:0] mirror_reg [0:15];

	// fuse data is valid the cycle after its read strobe
	assign copyDone = pend_reg && (pendAddr_reg == `CFGL_IDX_LAST);
	assign copyErr = copyDone && (errAcc_reg || fuseRdErr);
	assign copyBusy = fuseRd || pend_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fuseRd <= 1'b0;
			fuseAddr <= 4'h0;
		end else if (clearAll) begin
			fuseRd <= 1'b0;
			fuseAddr <= 4'h0;
		end else if (copyStart && !copyBusy) begin
			fuseRd <= 1'b1;
			fuseAddr <= 4'h0;
		end else if (fuseRd) begin
			fuseRd <= (fuseAddr != `CFGL_IDX_LAST);
			fuseAddr <= fuseAddr + 4'h1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pend_reg <= 1'b0;
			pendAddr_reg <= 4'h0;
			errAcc_reg <= 1'b0;
		end else begin
			pend_reg <= fuseRd && !clearAll;
			pendAddr_reg <= fuseAddr;
			if (clearAll || (copyStart && !copyBusy))
				errAcc_reg <= 1'b0;
			else if (pend_reg)
				errAcc_reg <= errAcc_reg || fuseRdErr;
		end
	end

	// a supply loss wipes any trial contents; capture beats host writes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `CFGL_NUM_CFG; i++)
				mirror_reg[i] <= `CFGL_CFG_RESET;
		end else if (clearAll) begin
			for (int i = 0; i < `CFGL_NUM_CFG; i++)
				mirror_reg[i] <= `CFGL_CFG_RESET;
		end else if (pend_reg) begin
			mirror_reg[pendAddr_reg] <= fuseRdData;
		end else if (hostWr) begin
			mirror_reg[hostIdx] <= hostData;
		end
	end

	always_comb begin
		for (int i = 0; i < `CFGL_NUM_CFG; i++)
			mirror[i] = mirror_reg[i];
	end

	// strobes of one copy, kept only for the span check
	logic [4:0] rdCount_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdCount_reg <= 5'h00;
		end else if (copyStart && !copyBusy) begin
			rdCount_reg <= 5'h00;
		end else if (fuseRd) begin
			rdCount_reg <= rdCount_reg + 5'h01;
		end
	end

	AST_COPY_SPAN: assert property (@(posedge mclk) disable iff (rst)
		copyDone |-> rdCount_reg == 5'h10)
		else $error("fuse copy did not span sixteen reads");
	AST_COPY_RUN: assert property (@(posedge mclk) disable iff (rst)
		fuseRd && (fuseAddr != `CFGL_IDX_LAST) && !clearAll |=> fuseRd)
		else $error("fuse reads broke off before the last word");
endmodule

/* File: core/cfgl_loader.sv */
// default configuration loader: source select, two-stage load, fail flags
`timescale 1ns/1ps
`include "cfgl_defs.svh"
//Contract
// - Source strap low: functional registers load from the fuse mirrors.
// - Source strap high: functional registers load from the hardwired set.
// - Source strap level is sampled at the moment of the register load.
// - Fuse source: copy all fuses into mirrors on each supply rising edge.
// - Second stage copies mirror contents into the functional registers.
// - Mirrors are host-writable while trial configuration mode is active.
// - Hardwired source reloads from the hardwired set and refuses trial mode.
// - Trim, fuse or self-test failure sets its flag and blocks power-up.
// - Failure flag writes are accepted only while the trial strap is high.
// - With trial strap low, failure flags are read-only; clears are ignored.
// - Trial strap high puts the device into trial configuration mode.
// - Page one shows mirrors only in trial mode; strap low denies pages.
// - Supply dropping below threshold resets the mirror registers.
module cfgl_loader (
	input wire logic mclk,
	input wire logic rst,
	input wire logic configSourceStrap,
	input wire logic trialConfigStrap,
	input wire logic inputSupplyOk,
	input wire logic powerUpRequest,
	input wire logic trimLoadFail,
	input wire logic selftestFail,
	output logic fuseRd,
	output logic [3:0] fuseAddr,
	input wire logic [7:0] fuseRdData,
	input wire logic fuseRdErr,
	input wire cfgl_pkg::cfgl_regreq_t regReq,
	output logic [7:0] regRdData,
	output logic regRdValid,
	output cfgl_pkg::cfgl_bank_t cfgRegs,
	output cfgl_pkg::cfgl_flags_t failFlags,
	output logic loadedFromHw,
	output logic trialConfigMode,
	output logic regulatorsOn,
	output logic quiescentOffState
);
	// pin synchronisers and edges
	logic [3:0] pinSync;
	logic supplyPrev_reg;
	logic pwrupPrev_reg;
	wire sourceHw = pinSync[`CFGL_PIN_SRC];
	wire trialStrap = pinSync[`CFGL_PIN_TRIAL];
	wire supplyOk = pinSync[`CFGL_PIN_SUPPLY];
	wire pwrupLevel = pinSync[`CFGL_PIN_POWER_UP_REQUEST];
	wire uvRise = supplyOk && !supplyPrev_reg;
	wire uvFall = !supplyOk && supplyPrev_reg;
	wire pwrupRise = pwrupLevel && !pwrupPrev_reg;

	cfgl_sync u_sync (
		.mclk(mclk),
		.rst(rst),
		.asyncIn({powerUpRequest, inputSupplyOk, trialConfigStrap,
			configSourceStrap}),
		.syncOut(pinSync)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			supplyPrev_reg <= 1'b0;
			pwrupPrev_reg <= 1'b0;
		end else begin
			supplyPrev_reg <= supplyOk;
			pwrupPrev_reg <= pwrupLevel;
		end
	end

	// register address decode
	function automatic logic [4:0] cfgIndex(input logic [7:0] a);
		case (a)
			`CFGL_OFF_B2_FAULT: return {1'b1, 4'h0};
			`CFGL_OFF_B2_LIMIT: return {1'b1, 4'h1};
			`CFGL_OFF_B2_SLOT: return {1'b1, 4'h2};
			`CFGL_OFF_B2_MODE: return {1'b1, 4'h3};
			`CFGL_OFF_B2_ACTV: return {1'b1, 4'h4};
			`CFGL_OFF_B2_STBY: return {1'b1, 4'h5};
			`CFGL_OFF_AUX_LIMIT: return {1'b1, 4'h6};
			`CFGL_OFF_AUX_SLOT: return {1'b1, 4'h7};
			`CFGL_OFF_AUX_MODE: return {1'b1, 4'h8};
			`CFGL_OFF_AUX_ACTV: return {1'b1, 4'h9};
			`CFGL_OFF_LIN_FAULT: return {1'b1, 4'hA};
			`CFGL_OFF_LIN_EN: return {1'b1, 4'hB};
			`CFGL_OFF_LIN_SLOT: return {1'b1, 4'hC};
			`CFGL_OFF_LIN_ACTV: return {1'b1, 4'hD};
			`CFGL_OFF_LIN_STBY: return {1'b1, 4'hE};
			`CFGL_OFF_BACKUP: return {1'b1, 4'hF};
			default: return {1'b0, 4'h0};
		endcase
	endfunction

	cfgl_pkg::cfgl_state_t state_reg;
	cfgl_pkg::cfgl_state_t state_next;
	logic [2:0] pageSel_reg;
	logic [2:0] pageSel_next;
	cfgl_pkg::cfgl_flags_t flags_reg;
	cfgl_pkg::cfgl_flags_t flags_next;
	cfgl_pkg::cfgl_bank_t func_reg;
	cfgl_pkg::cfgl_bank_t func_next;
	cfgl_pkg::cfgl_bank_t mirror;
	logic loadedFromHw_reg;
	logic copyBusy;
	logic copyDone;
	logic copyErr;

	wire [4:0] decoded = cfgIndex(regReq.addr);
	wire cfgHit = decoded[4];
	wire [3:0] cfgIdx = decoded[3:0];
	// hardwired source blocks trial mode even with the trial strap high
	wire trialMode = trialStrap && !sourceHw;
	wire mirrorView = trialMode && (pageSel_reg == `CFGL_PAGE_MIRROR);
	wire mirrorWr = regReq.wr && cfgHit && mirrorView;
	wire funcWr = regReq.wr && cfgHit && !mirrorView;
	wire pageWr = regReq.wr && (regReq.addr == `CFGL_OFF_PAGE);
	wire flagWr = regReq.wr && (regReq.addr == `CFGL_OFF_FLAGS);
	wire anyFlag = flags_reg.trim || flags_reg.fuse || flags_reg.selftest;
	wire inQuiescent = (state_reg == cfgl_pkg::ST_QUIESCENT);
	// clears need debug strap and quiescent state; the host keeps the latter
	wire flagClrEn = flagWr && trialStrap &&
		inQuiescent;
	wire startCopy = uvRise && !sourceHw &&
		(state_reg == cfgl_pkg::ST_UNPOWERED);
	wire funcLoad = (state_reg == cfgl_pkg::ST_FUNC_LOAD);
	wire cfgl_pkg::cfgl_bank_t hwBank = {`CFGL_NUM_CFG{`CFGL_HW_DEFAULT}};
	// source strap read here, at the load itself, not at supply rise
	wire cfgl_pkg::cfgl_bank_t loadBank =
		sourceHw ? hwBank : mirror;
	wire [2:0] clrMask = flagClrEn ? regReq.data[2:0] : 3'h0;
	wire [2:0] setMask = {selftestFail, copyErr, trimLoadFail};
	wire [7:0] flagRead = {5'h00, flags_reg};
	wire [7:0] pageRead = {5'h00, pageSel_reg};
	wire [7:0] cfgRead = mirrorView ? mirror[cfgIdx] : func_reg[cfgIdx];
	wire [7:0] rdMux = cfgHit ? cfgRead :
		(regReq.addr == `CFGL_OFF_PAGE) ? pageRead :
		(regReq.addr == `CFGL_OFF_FLAGS) ? flagRead : 8'h00;

	cfgl_mirror_bank u_mirror (
		.mclk(mclk),
		.rst(rst),
		.clearAll(uvFall),
		.copyStart(startCopy),
		.fuseRd(fuseRd),
		.fuseAddr(fuseAddr),
		.fuseRdData(fuseRdData),
		.fuseRdErr(fuseRdErr),
		.hostWr(mirrorWr),
		.hostIdx(cfgIdx),
		.hostData(regReq.data),
		.mirror(mirror),
		.copyBusy(copyBusy),
		.copyDone(copyDone),
		.copyErr(copyErr)
	);

	// power state sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			cfgl_pkg::ST_UNPOWERED: begin
				if (uvRise)
					state_next = sourceHw ? cfgl_pkg::ST_FUNC_LOAD :
						cfgl_pkg::ST_FUSE_COPY;
			end
			cfgl_pkg::ST_FUSE_COPY: begin
				if (copyDone)
					state_next = cfgl_pkg::ST_FUNC_LOAD;
			end
			cfgl_pkg::ST_FUNC_LOAD: begin
				state_next = cfgl_pkg::ST_QUIESCENT;
			end
			cfgl_pkg::ST_QUIESCENT: begin
				// requests before both stages never reach this state
				if (pwrupRise && !anyFlag)
					state_next = cfgl_pkg::ST_ACTIVE;
			end
			cfgl_pkg::ST_ACTIVE: begin
				if (!pwrupLevel)
					state_next = cfgl_pkg::ST_QUIESCENT;
			end
		endcase
		if (uvFall)
			state_next = cfgl_pkg::ST_UNPOWERED;
	end

	// flags: a failure in the clear cycle survives the clear
	always_comb begin
		flags_next = (flags_reg & ~clrMask) | setMask;
	end

	// low strap pins the page to zero so extended pages stay shut
	always_comb begin
		pageSel_next = pageSel_reg;
		if (!trialStrap)
			pageSel_next = `CFGL_PAGE_RESET;
		else if (pageWr)
			pageSel_next = regReq.data[`CFGL_PAGE_MSB:0];
	end

	// a load in progress overrides a host write in the same cycle
	always_comb begin
		func_next = func_reg;
		if (funcLoad)
			func_next = loadBank;
		else if (funcWr)
			func_next[cfgIdx] = regReq.data;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= cfgl_pkg::ST_UNPOWERED;
			pageSel_reg <= `CFGL_PAGE_RESET;
			flags_reg <= 3'h0;
			func_reg <= {`CFGL_NUM_CFG{`CFGL_CFG_RESET}};
		end else begin
			state_reg <= state_next;
			pageSel_reg <= pageSel_next;
			flags_reg <= flags_next;
			func_reg <= func_next;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			loadedFromHw_reg <= 1'b0;
		end else if (funcLoad) begin
			loadedFromHw_reg <= sourceHw;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			regRdData <= 8'h00;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regReq.rd;
			if (regReq.rd)
				regRdData <= rdMux;
		end
	end

	assign cfgRegs = func_reg;
	assign failFlags = flags_reg;
	assign loadedFromHw = loadedFromHw_reg;
	assign trialConfigMode = trialMode;
	assign regulatorsOn = (state_reg == cfgl_pkg::ST_ACTIVE);
	assign quiescentOffState = inQuiescent;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// fixed one-cycle fuse latency makes every step an exact count
	sequence seqFuseCopy;
		(state_reg == cfgl_pkg::ST_FUSE_COPY) ##16 copyDone;
	endsequence

	sequence seqLoadStage;
		(state_reg == cfgl_pkg::ST_FUNC_LOAD) ##1 inQuiescent;
	endsequence

	sequence seqHwLoad;
		(funcLoad && !fuseRd) ##1 (inQuiescent && !fuseRd);
	endsequence

	AST_FUSE_LOAD: assert property (funcLoad && !sourceHw |=>
		func_reg == $past(mirror))
		else $error("fuse source did not load mirrors");
	AST_HW_LOAD: assert property (funcLoad && sourceHw |=>
		func_reg == hwBank && loadedFromHw_reg)
		else $error("hardwired source did not load hardwired set");
	AST_SRC_AT_LOAD: assert property (funcLoad |=>
		loadedFromHw_reg == $past(sourceHw))
		else $error("source not taken at load time");
	AST_TWO_STAGE: assert property (startCopy && !uvFall |=>
		seqFuseCopy ##1 seqLoadStage)
		else $error("fuse copy did not lead to functional load");
	AST_STAGE_ORDER: assert property ($rose(inQuiescent) |->
		$past(state_reg) == cfgl_pkg::ST_FUNC_LOAD ||
		$past(state_reg) == cfgl_pkg::ST_ACTIVE)
		else $error("quiescent reached without functional load");
	AST_MIRROR_WR: assert property (mirrorWr && !uvFall &&
		!copyBusy |=> mirror[$past(cfgIdx)] == $past(regReq.data))
		else $error("trial mirror write lost");
	AST_HW_NO_TRIAL: assert property (sourceHw && !uvFall &&
		!copyBusy |=> $stable(mirror))
		else $error("mirror changed under hardwired source");
	AST_FLAG_BLOCK: assert property (anyFlag && inQuiescent |=>
		!regulatorsOn)
		else $error("power-up taken with failure flag set");
	AST_FLAG_SET: assert property (trimLoadFail || selftestFail || copyErr
		|=> (flags_reg & $past(setMask)) == $past(setMask))
		else $error("failure flag not set");
	AST_FLAG_CLEAR: assert property (flagClrEn && regReq.data[0] &&
		!trimLoadFail |=> !flags_reg.trim)
		else $error("accepted flag clear not applied");
	AST_FLAG_RO: assert property (!trialStrap |=>
		(flags_reg & $past(flags_reg)) == $past(flags_reg))
		else $error("flags cleared outside debug mode");
	AST_FLAG_KEEP: assert property (!trialStrap && anyFlag |=>
		anyFlag)
		else $error("flag dropped with strap low");
	AST_PAGE_DENY: assert property (!trialStrap |=>
		pageSel_reg == `CFGL_PAGE_RESET)
		else $error("extended page open with strap low");
	AST_UV_WIPE: assert property (uvFall |=>
		mirror == {`CFGL_NUM_CFG{`CFGL_CFG_RESET}} &&
		state_reg == cfgl_pkg::ST_UNPOWERED)
		else $error("mirrors kept after supply loss");
	AST_POWER_UP_REQUEST_GATE: assert property ($rose(regulatorsOn) |->
		$past(inQuiescent) && $past(pwrupRise))
		else $error("power-up before loading finished");

	// load path
	AST_COPY_REQ: assert property (startCopy && !copyBusy |=>
		fuseRd && fuseAddr == 4'h0)
		else $error("fuse copy did not start at word zero");
	AST_HW_PATH: assert property (uvRise && sourceHw &&
		state_reg == cfgl_pkg::ST_UNPOWERED |=> seqHwLoad)
		else $error("hardwired source did not load directly");
	AST_LOAD_ONCE: assert property (funcLoad |=> inQuiescent ||
		state_reg == cfgl_pkg::ST_UNPOWERED)
		else $error("functional load not followed by quiescent state");
	AST_FUNC_HOLD: assert property (!funcLoad && !funcWr |=>
		$stable(func_reg))
		else $error("functional registers changed without load or write");
	AST_UV_ABORT: assert property (uvFall |=> !fuseRd)
		else $error("fuse reads went on after supply loss");
	AST_POWER_UP_REQUEST_TAKE: assert property (pwrupRise && inQuiescent &&
		!anyFlag && !uvFall |=> regulatorsOn)
		else $error("clean power-up request not taken");

	// register port and flags
	AST_RD_ANSWER: assert property (regReq.rd |=> regRdValid)
		else $error("read answer missing");
	AST_FUNC_VIEW: assert property (regReq.rd && cfgHit &&
		!mirrorView |=> regRdData == $past(func_reg[cfgIdx]))
		else $error("denied page did not read functional register");
	AST_PAGE_OPEN: assert property (pageWr && trialStrap |=>
		pageSel_reg == $past(regReq.data[`CFGL_PAGE_MSB:0]))
		else $error("page write lost with trial strap high");
	AST_CLR_QUIET: assert property (flagWr && !inQuiescent |=>
		(flags_reg & $past(flags_reg)) == $past(flags_reg))
		else $error("flag cleared outside quiescent state");
	AST_TRIAL_HW: assert property (sourceHw |-> !trialConfigMode)
		else $error("trial mode entered with hardwired source");
endmodule

/* File: bench/cfgl_fuse_model.sv */
// behavioural fuse bank answering the loader's word reads
`timescale 1ns/1ps
module cfgl_fuse_model (
	input wire logic mclk,
	input wire logic fuseRd,
	input wire logic [3:0] fuseAddr,
	input wire cfgl_pkg::cfgl_bank_t contents,
	input wire logic errEn,
	output logic [7:0] fuseRdData,
	output logic fuseRdErr
);
	initial begin
		fuseRdData = 8'h00;
		fuseRdErr = 1'b0;
	end
	// one cycle latency; idle bus shows the inverse so stale data never passes
	always @(posedge mclk) begin
		if (fuseRd) begin
			fuseRdData <= contents[fuseAddr];
			fuseRdErr <= errEn;
		end else begin
			fuseRdData <= ~fuseRdData;
			fuseRdErr <= 1'b0;
		end
	end
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the default configuration loader
`timescale 1ns/1ps
`include "cfgl_defs.svh"
module tb_top;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic srcStrap = 1'b0;
	logic trialStrap = 1'b0;
	logic supplyOk = 1'b1;
	logic pwrReq = 1'b0;
	logic trimFail = 1'b0;
	logic stestFail = 1'b0;
	logic errEn = 1'b0;
	logic fuseRd;
	logic [3:0] fuseAddr;
	logic [7:0] fuseRdData;
	logic fuseRdErr;
	cfgl_pkg::cfgl_regreq_t regReq = '0;
	logic [7:0] regRdData;
	logic regRdValid;
	cfgl_pkg::cfgl_bank_t cfgRegs;
	cfgl_pkg::cfgl_bank_t fuseWords = '0;
	cfgl_pkg::cfgl_flags_t failFlags;
	logic loadedFromHw;
	logic trialConfigMode;
	logic regulatorsOn;
	logic quiescentOffState;
	logic [7:0] offs [16];
	logic [7:0] d;
	int seed = 32'ha06825c2;
	int errTotal = 0;
	int testsRun = 0;
	int k;

	always #25 mclk = ~mclk;

	cfgl_loader cfgl_loader_i (.mclk(mclk), .rst(rst),
		.configSourceStrap(srcStrap), .trialConfigStrap(trialStrap),
		.inputSupplyOk(supplyOk), .powerUpRequest(pwrReq),
		.trimLoadFail(trimFail), .selftestFail(stestFail),
		.fuseRd(fuseRd), .fuseAddr(fuseAddr), .fuseRdData(fuseRdData),
		.fuseRdErr(fuseRdErr), .regReq(regReq), .regRdData(regRdData),
		.regRdValid(regRdValid), .cfgRegs(cfgRegs), .failFlags(failFlags),
		.loadedFromHw(loadedFromHw), .trialConfigMode(trialConfigMode),
		.regulatorsOn(regulatorsOn), .quiescentOffState(quiescentOffState));

	cfgl_fuse_model cfgl_fuse_model_i (.mclk(mclk), .fuseRd(fuseRd),
		.fuseAddr(fuseAddr), .contents(fuseWords), .errEn(errEn),
		.fuseRdData(fuseRdData), .fuseRdErr(fuseRdErr));

	task automatic closeOut();
		if (errTotal == 0 && testsRun > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp) begin
			errTotal++;
			$display("Error at %0t: byte %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chkBit(input logic got, input logic exp);
		testsRun++;
		if (got !== exp) begin
			errTotal++;
			$display("Error at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic regWr(input logic [7:0] a, input logic [7:0] v);
		@(negedge mclk);
		regReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: v};
		@(negedge mclk);
		regReq = '0;
	endtask

	// read answer stands one cycle, sampled at the negedge after the take
	task automatic regRd(input logic [7:0] a, output logic [7:0] v);
		@(negedge mclk);
		regReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(negedge mclk);
		regReq = '0;
		chkBit(regRdValid, 1'b1);
		v = regRdData;
	endtask

	task automatic waitQuiet();
		int n;
		for (n = 0; n < 200 && quiescentOffState !== 1'b1; n++) begin
			@(negedge mclk);
		end
		chkBit(quiescentOffState, 1'b1);
	endtask

	task automatic newFuses();
		for (int i = 0; i < 16; i++) begin
			fuseWords[i] = 8'($random(seed));
		end
	endtask

	initial begin
		offs = '{`CFGL_OFF_B2_FAULT, `CFGL_OFF_B2_LIMIT, `CFGL_OFF_B2_SLOT,
			`CFGL_OFF_B2_MODE, `CFGL_OFF_B2_ACTV, `CFGL_OFF_B2_STBY,
			`CFGL_OFF_AUX_LIMIT, `CFGL_OFF_AUX_SLOT, `CFGL_OFF_AUX_MODE,
			`CFGL_OFF_AUX_ACTV, `CFGL_OFF_LIN_FAULT, `CFGL_OFF_LIN_EN,
			`CFGL_OFF_LIN_SLOT, `CFGL_OFF_LIN_ACTV, `CFGL_OFF_LIN_STBY,
			`CFGL_OFF_BACKUP};
		newFuses();
		cycles(2);
		rst = 1'b0;
		waitQuiet();
		for (k = 0; k < 16; k++) begin
			chkByte(cfgRegs[k], fuseWords[k]);
			regRd(offs[k], d);
			chkByte(d, fuseWords[k]);
		end
		chkBit(loadedFromHw, 1'b0);
		// index zero stays untouched for the trial mirror check below
		k = 1 + {$random(seed)} % 15;
		d = 8'($random(seed));
		regWr(offs[k], d);
		chkByte(cfgRegs[k], d);
		regRd(8'h60, d);
		chkByte(d, 8'h00);
		// page select refused while trial strap low
		regWr(`CFGL_OFF_PAGE, 8'h01);
		regRd(`CFGL_OFF_PAGE, d);
		chkByte(d, 8'h00);
		pwrReq = 1'b1;
		cycles(8);
		chkBit(regulatorsOn, 1'b1);
		pwrReq = 1'b0;
		cycles(8);
		chkBit(quiescentOffState, 1'b1);
		trialStrap = 1'b1;
		cycles(4);
		chkBit(trialConfigMode, 1'b1);
		regWr(`CFGL_OFF_PAGE, 8'h01);
		regWr(`CFGL_OFF_B2_FAULT, 8'hA5);
		regRd(`CFGL_OFF_B2_FAULT, d);
		chkByte(d, 8'hA5);
		chkByte(cfgRegs[0], fuseWords[0]);
		supplyOk = 1'b0;
		cycles(6);
		regRd(`CFGL_OFF_B2_FAULT, d);
		chkByte(d, 8'h00);
		trialStrap = 1'b0;
		// second load with a fuse read error and both failure pulses
		newFuses();
		errEn = 1'b1;
		supplyOk = 1'b1;
		waitQuiet();
		errEn = 1'b0;
		trimFail = 1'b1;
		stestFail = 1'b1;
		@(negedge mclk);
		trimFail = 1'b0;
		stestFail = 1'b0;
		@(negedge mclk);
		chkByte({5'h00, failFlags}, 8'h07);
		pwrReq = 1'b1;
		cycles(8);
		chkBit(regulatorsOn, 1'b0);
		pwrReq = 1'b0;
		regWr(`CFGL_OFF_FLAGS, 8'h07);
		chkByte({5'h00, failFlags}, 8'h07);
		trialStrap = 1'b1;
		cycles(4);
		// trim failure in the clear cycle must survive the clear
		@(negedge mclk);
		regReq = '{wr: 1'b1, rd: 1'b0, addr: `CFGL_OFF_FLAGS, data: 8'h07};
		trimFail = 1'b1;
		@(negedge mclk);
		regReq = '0;
		trimFail = 1'b0;
		chkByte({5'h00, failFlags}, 8'h01);
		regWr(`CFGL_OFF_FLAGS, 8'h07);
		chkByte({5'h00, failFlags}, 8'h00);
		trialStrap = 1'b0;
		// hardwired source chosen while unpowered, taken at the load
		supplyOk = 1'b0;
		srcStrap = 1'b1;
		cycles(6);
		supplyOk = 1'b1;
		waitQuiet();
		for (k = 0; k < 16; k++) begin
			chkByte(cfgRegs[k], `CFGL_HW_DEFAULT);
		end
		chkBit(loadedFromHw, 1'b1);
		trialStrap = 1'b1;
		cycles(4);
		chkBit(trialConfigMode, 1'b0);
		closeOut();
	end

	// whole run is well under a thousand cycles
	initial begin
		cycles(5000);
		errTotal++;
		closeOut();
	end
endmodule
